//--- include/etcp_params.svh
`ifndef ETCP_PARAMS_SVH
`define ETCP_PARAMS_SVH

// Register byte addresses on the AXI4-Lite slave
`define ETCP_ADDR_COUNT 8'h00
`define ETCP_ADDR_INTCTL 8'h04
`define ETCP_ADDR_OPTION 8'h08
`define ETCP_ADDR_WDT 8'h0c

// Option register field positions
`define ETCP_OPT_RATE_LSB 0
`define ETCP_OPT_RATE_MSB 2
`define ETCP_OPT_ASSIGN 3
`define ETCP_OPT_EDGE 4
`define ETCP_OPT_SOURCE 5

// Interrupt control field positions
`define ETCP_INT_FLAG 2
`define ETCP_INT_ENABLE 5

// Reset values
`define ETCP_OPTION_RESET 8'hff
`define ETCP_INTCTL_RESET 8'h00
`define ETCP_COUNT_RESET 8'h00

// Instruction cycle is four clocks; phases Q1..Q4 index 0..3
`define ETCP_PHASES 2'h3
`define ETCP_PHASE_Q2 2'h1
`define ETCP_PHASE_Q4 2'h3
`define ETCP_WRITE_HOLD_CYCLES 2'h2

// Watchdog register layout: bit 0 write clears, reads return all zeros
`define ETCP_WDT_CLEAR 0

// AXI responses
`define ETCP_RESP_OKAY 2'h0
`define ETCP_RESP_SLVERR 2'h2

`endif

//--- include/etcp_pkg.sv
package etcp_pkg;

  typedef struct packed {
    logic source_select;
    logic edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_rate;
  } etcp_config_t;

  typedef enum logic [2:0] {
    etcp_wr_idle = 3'h1,
    etcp_wr_resp = 3'h2,
    etcp_wr_hold = 3'h4
  } etcp_wr_state_t;

endpackage : etcp_pkg

//--- hdl/etcp_prescaler.sv
`timescale 1ns/100ps
`include "etcp_params.svh"

module etcp_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [2:0] rate,
  output logic tick_out
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] mask;

  // Division ratio 2^(rate+1): tick on wrap of the low rate+1 bits
  always_comb begin
    mask = 8'hff >> (3'h7 - rate);
    next_count = count + 8'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
    end else if (ce) begin
      if (clear) begin
        count <= 8'h00;
      end else if (tick_in) begin
        count <= next_count;
      end
    end
  end

  // Combinational so the counter sees the divided event in the same cycle
  assign tick_out = tick_in && !clear && ((count & mask) == mask);

endmodule : etcp_prescaler

//--- hdl/etcp_timer.sv
// Functional notes
// - Eight-bit up counter, software readable and writable, internal or external source.
// - Source select clear: count once per instruction cycle, clock divided by four.
// - Source select set: count edges on the external count input.
// - Edge select set counts falling edges, clear counts rising edges.
// - No counting for two instruction cycles after a count write.
// - One prescaler serves timer or watchdog; assign bit set gives it to watchdog.
// - Rate field selects timer division 1:2 up to 1:256 by powers of two.
// - Timer counts undivided only while prescaler belongs to the watchdog.
// - Prescaler count is not visible or writable through any register.
// - Count write clears the prescaler while it belongs to the timer.
// - Watchdog clear resets watchdog and prescaler while assigned to watchdog.
// - Wrap from FFh to 00h sets the overflow flag.
// - Flag sets regardless of enable; enable only gates the request.
// - Counter frozen during sleep, so overflow cannot wake the core.
// - External input synchronised, its edges handed to the prescaler on Q2 and Q4.
// - Overflow enable is a dedicated bit in interrupt control, bit 5, with the flag at bit 2.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "etcp_params.svh"

module etcp_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sleep,
  input wire logic ext_count_input,
  input wire logic watchdog_clear_instr,
  output logic overflow_irq,
  output logic watchdog_tick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [7:0] timer_count;
  logic [7:0] option_config;
  logic [7:0] interrupt_control;
  etcp_pkg::etcp_config_t cfg;
  logic [1:0] phase;
  logic [1:0] hold_left;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic src_edge;
  logic src_seen;
  logic src_event;
  logic pre_tick;
  logic pre_clear;
  logic count_event;
  logic overflow;
  logic q4;

  logic have_aw;
  logic have_w;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_low;
  logic count_write;
  logic wdt_clear;

  assign cfg = '{
    source_select: option_config[`ETCP_OPT_SOURCE],
    edge_select: option_config[`ETCP_OPT_EDGE],
    prescaler_assign: option_config[`ETCP_OPT_ASSIGN],
    prescale_rate: option_config[`ETCP_OPT_RATE_MSB:`ETCP_OPT_RATE_LSB]
  };

  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture, either order

  assign s_axi_awready = !have_aw && !s_axi_bvalid;
  assign s_axi_wready = !have_w && !s_axi_bvalid;
  assign wr_fire = have_aw && have_w && !s_axi_bvalid;
  assign wr_low = w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw <= 1'b0;
      aw_addr <= 8'h00;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        have_aw <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_w <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        have_w <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ETCP_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `ETCP_ADDR_COUNT, `ETCP_ADDR_INTCTL, `ETCP_ADDR_OPTION, `ETCP_ADDR_WDT: begin
            s_axi_bresp <= `ETCP_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `ETCP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign count_write = wr_fire && wr_low && (aw_addr == `ETCP_ADDR_COUNT);
  // Watchdog clear from the core pin or a register write
  assign wdt_clear = watchdog_clear_instr
    || (wr_fire && wr_low && (aw_addr == `ETCP_ADDR_WDT) && w_data[`ETCP_WDT_CLEAR]);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_config <= `ETCP_OPTION_RESET;
    end else if (ce && wr_fire && wr_low && aw_addr == `ETCP_ADDR_OPTION) begin
      option_config <= w_data[7:0];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_control <= `ETCP_INTCTL_RESET;
    end else if (ce) begin
      if (wr_fire && wr_low && aw_addr == `ETCP_ADDR_INTCTL) begin
        interrupt_control <= w_data[7:0];
      end
      if (overflow) begin
        interrupt_control[`ETCP_INT_FLAG] <= 1'b1;
      end
    end
  end

  assign overflow_irq = interrupt_control[`ETCP_INT_FLAG]
    && interrupt_control[`ETCP_INT_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle phases and external input

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 2'h0;
    end else if (ce && !sleep) begin
      phase <= phase + 2'h1;
    end
  end

  assign q4 = (phase == `ETCP_PHASE_Q4);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else if (ce) begin
      ext_meta <= ext_count_input;
      ext_sync <= ext_meta;
    end
  end

  // Falling edge when edge select is set, rising edge otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev <= 1'b0;
    end else if (ce) begin
      ext_prev <= ext_sync;
    end
  end

  assign src_edge = cfg.edge_select ? (ext_prev && !ext_sync)
    : (!ext_prev && ext_sync);

  // Edges are latched and handed to the prescaler only on Q2 and Q4
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_seen <= 1'b0;
    end else if (ce) begin
      if (!cfg.source_select || phase == `ETCP_PHASE_Q2 || q4) begin
        src_seen <= 1'b0;
      end else if (src_edge) begin
        src_seen <= 1'b1;
      end
    end
  end

  always_comb begin
    if (cfg.source_select) begin
      src_event = (phase == `ETCP_PHASE_Q2 || q4) && (src_seen || src_edge);
    end else begin
      src_event = q4;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler

  // Prescaler count has no register path; only its tick is observed
  assign pre_clear = cfg.prescaler_assign ? wdt_clear : count_write;

  etcp_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .clear(pre_clear),
    .tick_in(cfg.prescaler_assign ? 1'b1 : (src_event && !sleep)),
    .rate(cfg.prescale_rate),
    .tick_out(pre_tick)
  );

  assign watchdog_tick = cfg.prescaler_assign && pre_tick;

  // Undivided only while the prescaler is lent to the watchdog
  assign count_event = cfg.prescaler_assign ? src_event : pre_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Count register

  // Hold counts instruction-cycle boundaries after a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_left <= 2'h0;
    end else if (ce) begin
      if (count_write) begin
        hold_left <= `ETCP_WRITE_HOLD_CYCLES;
      end else if (q4 && hold_left != 2'h0 && !sleep) begin
        hold_left <= hold_left - 2'h1;
      end
    end
  end

  assign overflow = ce && !sleep && !count_write && hold_left == 2'h0
    && count_event && timer_count == 8'hff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count <= `ETCP_COUNT_RESET;
    end else if (ce) begin
      if (count_write) begin
        timer_count <= w_data[7:0];
      end else if (!sleep && hold_left == 2'h0 && count_event) begin
        timer_count <= timer_count + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ETCP_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ETCP_RESP_OKAY;
        case (s_axi_araddr)
          `ETCP_ADDR_COUNT: begin
            s_axi_rdata <= {24'h000000, timer_count};
          end
          `ETCP_ADDR_INTCTL: begin
            s_axi_rdata <= {24'h000000, interrupt_control};
          end
          `ETCP_ADDR_OPTION: begin
            s_axi_rdata <= {24'h000000, option_config};
          end
          `ETCP_ADDR_WDT: begin
            s_axi_rdata <= 32'h0000_0000;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ETCP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : etcp_timer

//--- testbench/etcp_timer_sva.sv
`timescale 1ns/100ps
module etcp_timer_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic overflow_irq,
  input wire logic watchdog_tick
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  b_late_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after request");
  r_next_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  w_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // The flag may only fall at the edge where a register write lands
  irq_keep_a: assert property (
    overflow_irq |=> overflow_irq || $rose(s_axi_bvalid))
    else $error("overflow request cleared by hardware");
  byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  tick_pulse_a: assert property (watchdog_tick |=> !watchdog_tick)
    else $error("watchdog tick longer than one cycle");
endmodule : etcp_timer_sva

//--- testbench/etcp_pulse_src.sv
`timescale 1ns/100ps
module etcp_pulse_src (
  input wire logic aclk,
  output logic ext_count_input
);
  initial ext_count_input = 1'b0;
  // Four clocks a level so every level spans a Q2 and a Q4 sample
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (4) @(posedge aclk);
      ext_count_input <= ~ext_count_input;
    end
  endtask : toggle
endmodule : etcp_pulse_src

//--- testbench/test_eight_bit_timer_counter_prescaler.sv
`timescale 1ns/100ps
`include "etcp_params.svh"
module test_eight_bit_timer_counter_prescaler;
  logic aclk = 1'b0, aresetn = 1'b0, sleep = 1'b0, watchdog_clear_instr = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, a, b;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic ext_count_input, overflow_irq, watchdog_tick, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int n_errors = 0, samples_checked = 0, cyc = 0, k;
  localparam logic [7:0] cnt = `ETCP_ADDR_COUNT;
  localparam logic [7:0] ictl = `ETCP_ADDR_INTCTL;
  localparam logic [7:0] opt = `ETCP_ADDR_OPTION;
  always #25 aclk = ~aclk;
  etcp_timer DUT (.aclk, .aresetn, .ce(1'b1), .sleep, .ext_count_input,
    .watchdog_clear_instr, .overflow_irq, .watchdog_tick, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  etcp_pulse_src src (.aclk, .ext_count_input);
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      close_out;
    end
  end
  // Local flags track each half, since the valids only update after the edge
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (s_axi_awready) aw_left = 1'b0;
      if (s_axi_wready) w_left = 1'b0;
      s_axi_awvalid <= aw_left;
      s_axi_wvalid <= w_left;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : wr
  // Fixed three-edge cost lets two reads be placed an exact distance apart
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
  endtask : rd
  task automatic wd_clear;
    @(posedge aclk);
    watchdog_clear_instr <= 1'b1;
    @(posedge aclk);
    watchdog_clear_instr <= 1'b0;
  endtask : wd_clear
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(opt, a);
    check("option reset", a, 8'hff);
    rd(ictl, a);
    check("intctl reset", a, 8'h00);
    rd(`ETCP_ADDR_WDT, a);
    check("prescaler hidden", a, 8'h00);
    rd(8'h10, a);
    check("unmapped", {resp, a}, {`ETCP_RESP_SLVERR, 8'h00});
    wr(8'h10, 8'h55);
    check("unmapped write", resp, `ETCP_RESP_SLVERR);
    wr(opt, 8'h0f);
    check("option write", resp, `ETCP_RESP_OKAY);
    wr(cnt, 8'ha5);
    // Sampled eight clocks after the write, after the two-cycle hold but before the next count
    repeat (5) @(posedge aclk);
    rd(cnt, a);
    check("count load", a, 8'ha5);
    for (k = 0; k < 9; k++) begin
      wr(opt, (k == 8) ? 8'h0f : 8'(k));
      rd(cnt, a);
      repeat (((k == 8) ? 20 : (40 << k)) - 3) @(posedge aclk);
      rd(cnt, b);
      check("timer rate", 8'(b - a), 8'h05);
    end
    sleep <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(cnt, a);
    repeat (200) @(posedge aclk);
    rd(cnt, b);
    sleep <= 1'b0;
    check("sleep freeze", b, a);
    wr(ictl, 8'h00);
    wr(cnt, 8'hfe);
    repeat (40) @(posedge aclk);
    rd(ictl, a);
    check("flag masked", {a, overflow_irq}, {8'h04, 1'b0});
    wr(ictl, 8'h24);
    check("irq on", overflow_irq, 1'b1);
    repeat (1100) @(posedge aclk);
    rd(ictl, a);
    check("flag kept", a, 8'h24);
    wr(ictl, 8'h20);
    check("irq off", overflow_irq, 1'b0);
    wr(cnt, 8'hfe);
    repeat (40) @(posedge aclk);
    check("irq again", overflow_irq, 1'b1);
    wr(ictl, 8'h00);
    for (k = 0; k < 2; k++) begin
      if (src.ext_count_input) src.toggle(1);
      wr(opt, k ? 8'h3f : 8'h2f);
      repeat (10) @(posedge aclk);
      wr(cnt, 8'h00);
      repeat (12) @(posedge aclk);
      src.toggle(9);
      repeat (12) @(posedge aclk);
      rd(cnt, a);
      check("edge count", a, k ? 8'h04 : 8'h05);
    end
    for (k = 0; k < 3; k++) begin
      if (src.ext_count_input) src.toggle(1);
      wd_clear;
      wr(opt, 8'h20 + 8'(k));
      src.toggle(2);
      wr(cnt, 8'h00);
      repeat (12) @(posedge aclk);
      src.toggle((8 << k) - 3);
      repeat (12) @(posedge aclk);
      rd(cnt, a);
      check("prescaled edges", a, 8'h01);
    end
    // Hand the prescaler back to the watchdog in the safe order
    wd_clear;
    wr(cnt, 8'h00);
    wr(opt, 8'h0f);
    wd_clear;
    k = 0;
    while (!watchdog_tick && k < 300) begin
      @(posedge aclk);
      k++;
    end
    check("tick after clear", k > 120 && k < 260, 1'b1);
    wr(`ETCP_ADDR_WDT, 8'h01);
    k = 0;
    while (!watchdog_tick && k < 300) begin
      @(posedge aclk);
      k++;
    end
    check("tick after reg clear", k > 120 && k < 260, 1'b1);
    close_out;
  end
endmodule : test_eight_bit_timer_counter_prescaler
bind etcp_timer etcp_timer_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .overflow_irq, .watchdog_tick);
